// ---- pfrw_params.svh ----
// constants for the program flash row writer
`ifndef PFRW_PARAMS_SVH
`define PFRW_PARAMS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define PFRW_OFS_ADDR_LOW    4'h0
`define PFRW_OFS_ADDR_HIGH   4'h1
`define PFRW_OFS_DATA_LOW    4'h2
`define PFRW_OFS_DATA_HIGH   4'h3
`define PFRW_OFS_CONTROL     4'h4
`define PFRW_OFS_UNLOCK      4'h5
`define PFRW_OFS_STATUS      4'h6

// ****************************************
// control register fields
// ****************************************
`define PFRW_BIT_RD          0
`define PFRW_BIT_WR          1
`define PFRW_BIT_PROGRAM_ENABLE        2
`define PFRW_BIT_WRERR       3
`define PFRW_BIT_FREE        4
`define PFRW_BIT_LATCH_ONLY_MODE        5
`define PFRW_BIT_CONFIG_SPACE_SELECT        6
`define PFRW_CTRL_RST        8'h80

// ****************************************
// values and timing
// ****************************************
`define PFRW_BLANK_WORD      14'h3fff
`define PFRW_KEY_FIRST       8'h55
`define PFRW_KEY_SECOND      8'haa
`define PFRW_ADDR_HIGH_RST   8'h80
`define PFRW_NOP_CYCLES      2
`define PFRW_CLK_MHZ         40
`define PFRW_WRITE_TIME_US   2000
`define PFRW_WRITE_CYCLES    (`PFRW_WRITE_TIME_US * `PFRW_CLK_MHZ)
`define PFRW_LATCHES         16

`endif

// ---- pfrw_pkg.sv ----
// types shared by the program flash row writer
package pfrw_pkg;

    typedef enum logic [2:0] {
        PFRW_IDLE   = 3'b000,
        PFRW_NOP    = 3'b001,
        PFRW_BUSY   = 3'b010,
        PFRW_FINISH = 3'b011
    } pfrw_state_t;

    typedef enum logic [1:0] {
        PFRW_KEY_NONE = 2'b00,
        PFRW_KEY_GOT1 = 2'b01,
        PFRW_KEY_GOT2 = 2'b10
    } pfrw_key_t;

    // command to the flash array
    typedef struct packed {
        logic        prog;
        logic        erase;
        logic [10:0] row;
    } pfrw_array_cmd_t;

endpackage

// ---- pfrw_latch_bank.sv ----
// sixteen write latches of one flash row
`timescale 1ns/1ps
`include "pfrw_params.svh"

module pfrw_latch_bank (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [3:0]   sel,
    input  wire logic [13:0]  wdata,
    input  wire logic         blank_all,
    output logic [13:0]       latch [0:15]
);
    import pfrw_pkg::*;

    // ****************************************
    // per-latch storage
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `PFRW_LATCHES; g++) begin : g_latch
            always_ff @(posedge clk_sys) begin
                if (rst || blank_all) begin
                    latch[g] <= `PFRW_BLANK_WORD;
                end else if (load && sel == 4'(g)) begin
                    latch[g] <= wdata;
                end
            end
        end
    endgenerate
endmodule

// ---- pfrw_top.sv ----
// program flash self-write controller with avalon-mm register slave
//
// Contract
// - row from upper 11 bits, latch from low four
// - program only the selected row, no wrap
// - latches return to blank after any program or erase
// - unloaded latches stay blank when committed
// - program does no automatic erase first
// - at most sixteen words per program
// - latch-only mode loads latch, no programming
// - otherwise load latch then program row
// - broken unlock starts nothing
// - latch load: two forced no-ops, stall for those two only
// - row program stalls core until done
// - unlock is 55h, AAh, then write start
// - erase or program halts core about 2 ms
// - enable clear refuses program and erase
// - erase ignores latch-only mode
`timescale 1ns/1ps
`include "pfrw_params.svh"

module pfrw_top #(
    parameter int unsigned WRITE_CYCLES = `PFRW_WRITE_CYCLES
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           core_stall,
    output pfrw_pkg::pfrw_array_cmd_t      array_cmd,
    output logic [13:0]                    array_word [0:15],
    input  wire logic                      array_done
);
    import pfrw_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]        flash_addr_low_ff;
    logic [7:0]        flash_addr_high_ff;
    logic [7:0]        flash_data_low_ff;
    logic [7:0]        flash_data_high_ff;
    logic              config_space_select_ff;
    logic              latch_only_mode_ff;
    logic              erase_select_ff;
    logic              write_error_ff;
    logic              program_enable_ff;
    logic              write_start_ff;
    logic              read_start_ff;
    pfrw_key_t         key_ff;
    pfrw_state_t       state_ff;
    logic [31:0]       busy_cnt_ff;
    logic [1:0]        nop_cnt_ff;
    logic              op_array_ff;
    logic              ack_ff;
    logic              waitreq_ff;
    logic [31:0]       rdata_ff;
    logic              stall_ff;
    pfrw_array_cmd_t   cmd_ff;
    logic [13:0]       latch [0:15];

    logic              req;
    logic              wr_hit;
    logic              wr_ctrl;
    logic              wr_key;
    logic              start_ok;
    logic              do_load;
    logic              do_array;
    logic              blank_all;
    logic [10:0]       row_sel;
    logic [7:0]        ctrl_view;

    assign req    = (avs_read || avs_write) && !ack_ff;
    assign wr_hit = avs_write && !ack_ff && avs_byteenable[0];
    assign wr_ctrl = wr_hit && avs_address == `PFRW_OFS_CONTROL;
    assign wr_key  = wr_hit && avs_address == `PFRW_OFS_UNLOCK;
    assign row_sel = {flash_addr_high_ff[6:0], flash_addr_low_ff[7:4]};

    // write start accepted only straight after the two keys
    assign start_ok = wr_ctrl && avs_writedata[`PFRW_BIT_WR]
                      && !write_start_ff && state_ff == PFRW_IDLE
                      && key_ff == PFRW_KEY_GOT2
                      && program_enable_ff;
    assign do_load  = start_ok && !erase_select_ff;
    assign do_array = start_ok && (erase_select_ff
                      || !latch_only_mode_ff);
    // blank on the very edge that ends the array operation, with the stall
    assign blank_all = state_ff == PFRW_BUSY
                       && (busy_cnt_ff == 32'd1 || array_done);

    assign ctrl_view = {1'b1, config_space_select_ff, latch_only_mode_ff,
                        erase_select_ff, write_error_ff, program_enable_ff,
                        write_start_ff, read_start_ff};

    // ****************************************
    // latch bank
    // ****************************************
    pfrw_latch_bank u_latch (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .load      (do_load),
        .sel       (flash_addr_low_ff[3:0]),
        .wdata     ({flash_data_high_ff[5:0], flash_data_low_ff}),
        .blank_all (blank_all),
        .latch     (latch)
    );

    // ****************************************
    // bus handshake: one wait cycle per access
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_ff     <= 1'b0;
            waitreq_ff <= 1'b1;
        end else begin
            ack_ff     <= req;
            waitreq_ff <= !req;
        end
    end

    assign avs_waitrequest = waitreq_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= 32'h0;
        end else if (avs_read && !ack_ff) begin
            case (avs_address)
                `PFRW_OFS_ADDR_LOW:  rdata_ff <= {24'h0, flash_addr_low_ff};
                `PFRW_OFS_ADDR_HIGH: rdata_ff <= {24'h0, flash_addr_high_ff};
                `PFRW_OFS_DATA_LOW:  rdata_ff <= {24'h0, flash_data_low_ff};
                `PFRW_OFS_DATA_HIGH: rdata_ff <= {24'h0, flash_data_high_ff};
                `PFRW_OFS_CONTROL:   rdata_ff <= {24'h0, ctrl_view};
                `PFRW_OFS_STATUS:    rdata_ff <= {29'h0, state_ff};
                default:             rdata_ff <= 32'h0;
            endcase
        end
    end

    assign avs_readdata = rdata_ff;

    // ****************************************
    // address and data pairs
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flash_addr_low_ff  <= 8'h00;
            flash_addr_high_ff <= `PFRW_ADDR_HIGH_RST;
            flash_data_low_ff  <= 8'h00;
            flash_data_high_ff <= 8'h00;
        end else if (wr_hit) begin
            case (avs_address)
                `PFRW_OFS_ADDR_LOW:  flash_addr_low_ff <= avs_writedata[7:0];
                `PFRW_OFS_ADDR_HIGH: flash_addr_high_ff <=
                                     {1'b1, avs_writedata[6:0]};
                `PFRW_OFS_DATA_LOW:  flash_data_low_ff <= avs_writedata[7:0];
                `PFRW_OFS_DATA_HIGH: flash_data_high_ff <=
                                     {2'b00, avs_writedata[5:0]};
                default: ;
            endcase
        end
    end

    // ****************************************
    // control bits
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            config_space_select_ff <= 1'b0;
            latch_only_mode_ff     <= 1'b0;
            erase_select_ff        <= 1'b0;
            program_enable_ff      <= 1'b0;
            read_start_ff          <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                config_space_select_ff <= avs_writedata[`PFRW_BIT_CONFIG_SPACE_SELECT];
                latch_only_mode_ff     <= avs_writedata[`PFRW_BIT_LATCH_ONLY_MODE];
                program_enable_ff      <= avs_writedata[`PFRW_BIT_PROGRAM_ENABLE];
            end
            // erase select clears itself when an erase finishes
            if (blank_all && !op_array_ff) begin
                erase_select_ff <= erase_select_ff;
            end else if (blank_all && erase_select_ff) begin
                erase_select_ff <= 1'b0;
            end else if (wr_ctrl) begin
                erase_select_ff <= avs_writedata[`PFRW_BIT_FREE];
            end
            // reads are outside this block; the request clears at once
            read_start_ff <= 1'b0;
        end
    end

    // write start can only be set by software and is cleared by hardware
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            write_start_ff <= 1'b0;
        end else if (start_ok) begin
            write_start_ff <= 1'b1;
        end else if (blank_all || (state_ff == PFRW_NOP && nop_cnt_ff == 2'd1
                     && !op_array_ff)) begin
            write_start_ff <= 1'b0;
        end
    end

    // error flag: a start attempt without a valid unlock or enable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            write_error_ff <= 1'b0;
        end else if (wr_ctrl && avs_writedata[`PFRW_BIT_WR] && !start_ok
                     && !write_start_ff) begin
            write_error_ff <= 1'b1;
        end else if (wr_ctrl) begin
            write_error_ff <= avs_writedata[`PFRW_BIT_WRERR];
        end
    end

    // ****************************************
    // unlock key tracker
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            key_ff <= PFRW_KEY_NONE;
        end else if (wr_key && avs_writedata[7:0] == `PFRW_KEY_FIRST) begin
            key_ff <= PFRW_KEY_GOT1;
        end else if (wr_key && key_ff == PFRW_KEY_GOT1
                     && avs_writedata[7:0] == `PFRW_KEY_SECOND) begin
            key_ff <= PFRW_KEY_GOT2;
        end else if (avs_write && !ack_ff) begin
            // any other write breaks the sequence
            key_ff <= PFRW_KEY_NONE;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff    <= PFRW_IDLE;
            nop_cnt_ff  <= 2'd0;
            op_array_ff <= 1'b0;
        end else begin
            case (state_ff)
                PFRW_IDLE: begin
                    if (start_ok) begin
                        state_ff    <= PFRW_NOP;
                        nop_cnt_ff  <= 2'(`PFRW_NOP_CYCLES);
                        op_array_ff <= do_array;
                    end
                end
                PFRW_NOP: begin
                    // two forced no-op cycles for every start
                    if (nop_cnt_ff == 2'd1) begin
                        state_ff <= op_array_ff ? PFRW_BUSY
                                                : PFRW_IDLE;
                    end
                    nop_cnt_ff <= nop_cnt_ff - 2'd1;
                end
                PFRW_BUSY: begin
                    if (busy_cnt_ff == 32'd1 || array_done) begin
                        state_ff <= PFRW_FINISH;
                    end
                end
                PFRW_FINISH: begin
                    state_ff <= PFRW_IDLE;
                end
                default: state_ff <= PFRW_IDLE;
            endcase
        end
    end

    // self-timed write; array_done may end it early
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_cnt_ff <= 32'd0;
        end else if (state_ff == PFRW_NOP && nop_cnt_ff == 2'd1) begin
            busy_cnt_ff <= WRITE_CYCLES;
        end else if (state_ff == PFRW_BUSY && busy_cnt_ff != 32'd0) begin
            busy_cnt_ff <= busy_cnt_ff - 32'd1;
        end
    end

    // core halts through no-ops and the whole array operation
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stall_ff <= 1'b0;
        end else begin
            stall_ff <= start_ok || (state_ff == PFRW_NOP
                        && nop_cnt_ff != 2'd1) || (state_ff == PFRW_NOP
                        && op_array_ff) || (state_ff == PFRW_BUSY
                        && !(busy_cnt_ff == 32'd1 || array_done));
        end
    end

    assign core_stall = stall_ff;

    // ****************************************
    // array command: one row, latch bank as data
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_ff <= '0;
        end else if (state_ff == PFRW_NOP && nop_cnt_ff == 2'd1
                     && op_array_ff) begin
            cmd_ff.prog  <= !erase_select_ff;
            cmd_ff.erase <= erase_select_ff;
            cmd_ff.row   <= row_sel;
        end else if (state_ff != PFRW_BUSY || blank_all) begin
            cmd_ff <= '0;
        end
    end

    assign array_cmd = cmd_ff;

    // sixteen words exactly, blank where not loaded
    genvar g;
    generate
        for (g = 0; g < `PFRW_LATCHES; g++) begin : g_word
            assign array_word[g] = latch[g];
        end
    endgenerate
endmodule

// ---- pfrw_top_asserts.sv ----
// assertion checker for the program flash row writer
`timescale 1ns/1ps
module pfrw_top_asserts
    import pfrw_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 core_stall,
    input wire pfrw_pkg::pfrw_array_cmd_t array_cmd,
    input wire logic [13:0]          array_word [0:15]
);
    import pfrw_pkg::*;
    logic [223:0] latch_vec;
    logic         busy;
    int unsigned  busy_cnt;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            latch_vec[i*14 +: 14] = array_word[i];
        end
    end
    assign busy = array_cmd.prog | array_cmd.erase;

    // long array waits are counted, not unrolled
    always_ff @(posedge clk_sys) begin
        if (rst || !busy) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_start;
        $rose(core_stall);
    endsequence
    sequence s_op_end;
        $fell(busy);
    endsequence

    chk_nop_pair: assert property (s_start |-> core_stall[*2])
        else $error("stall shorter than two forced cycles");
    chk_busy_bound: assert property (busy_cnt <= WRITE_CYCLES + 4)
        else $error("array operation outlasts its timer");
    chk_resume_idle: assert property ($fell(core_stall) |-> !busy)
        else $error("core resumed while array busy");
    chk_stall_cover: assert property (busy |-> core_stall)
        else $error("array busy without core stall");
    chk_blank_end: assert property (s_op_end |-> ##[0:2]
        latch_vec == {16{14'h3fff}})
        else $error("latches not blank after operation");
    chk_row_hold: assert property (busy && $past(busy)
        |-> $stable(array_cmd.row))
        else $error("row changed during operation");
    chk_latch_quiet: assert property ($changed(latch_vec)
        |-> $past(core_stall) or ##[0:1] core_stall)
        else $error("latch changed without a started operation");
    chk_cmd_after_nop: assert property ($rose(busy)
        |-> $past(core_stall, 2))
        else $error("array command without preceding forced cycles");
    chk_one_kind: assert property (!(array_cmd.prog && array_cmd.erase))
        else $error("program and erase issued together");
endmodule

// ---- pfrw_flash_model.sv ----
// flash array model facing the program flash row writer
`timescale 1ns/1ps
module pfrw_flash_model
    import pfrw_pkg::*;
#(
    parameter int DONE_DLY = 6
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire pfrw_pkg::pfrw_array_cmd_t array_cmd,
    input  wire logic [13:0]          array_word [0:15],
    output logic                      array_done,
    output logic [7:0]                prog_cnt,
    output logic [7:0]                erase_cnt
);
    logic [13:0] mem [0:32767];
    logic        busy_ff;
    int          wait_ff;
    logic        go;

    function automatic logic [13:0] peek(input logic [14:0] a);
        return mem[a];
    endfunction

    assign go = array_cmd.prog | array_cmd.erase;

    initial begin
        array_done = 1'b0;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 14'h3fff;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            busy_ff    <= 1'b0;
            wait_ff    <= 0;
            array_done <= 1'b0;
            prog_cnt   <= 8'h00;
            erase_cnt  <= 8'h00;
        end else begin
            busy_ff    <= go;
            wait_ff    <= go ? wait_ff + 1 : 0;
            // erase ends on the design's own timer, program on done
            array_done <= go && array_cmd.prog && (wait_ff == DONE_DLY - 1);
            if (go && !busy_ff && array_cmd.erase) begin
                erase_cnt <= erase_cnt + 8'h01;
                for (int i = 0; i < 16; i++) begin
                    mem[{array_cmd.row, i[3:0]}] = 14'h3fff;
                end
            end else if (go && !busy_ff) begin
                prog_cnt <= prog_cnt + 8'h01;
                // cells only lose ones: no erase before a program
                for (int i = 0; i < 16; i++) begin
                    mem[{array_cmd.row, i[3:0]}] &= array_word[i];
                end
            end
        end
    end
endmodule

// ---- test_pfrw_top.sv ----
// self-checking testbench for the program flash row writer
`timescale 1ns/1ps
module test_pfrw_top;
    import pfrw_pkg::*;
    localparam int WC = 20;
    logic            clk_sys, rst, avs_read, avs_write, array_done;
    logic            avs_waitrequest, core_stall;
    logic [3:0]      avs_address, avs_byteenable;
    logic [31:0]     avs_writedata, avs_readdata;
    logic [13:0]     array_word [0:15];
    pfrw_array_cmd_t array_cmd;
    logic [7:0]      prog_cnt, erase_cnt, q;
    int              miscompares, checks, n;

    pfrw_top #(.WRITE_CYCLES(WC)) i_pfrw_top (.clk_sys, .rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .core_stall, .array_cmd, .array_word, .array_done);
    pfrw_flash_model i_pfrw_flash_model (.clk_sys, .rst, .array_cmd,
        .array_word, .array_done, .prog_cnt, .erase_cnt);

    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] al, input logic [13:0] w);
        bus(1, 4'h0, al);
        bus(1, 4'h2, w[7:0]);
        bus(1, 4'h3, {2'b00, w[13:8]});
    endtask
    // brk slips a data write between the two keys; n = stall cycles
    task automatic start(input logic [7:0] ctrl, input logic brk);
        bus(1, 4'h5, 8'h55);
        if (brk) bus(1, 4'h2, 8'hbc);
        bus(1, 4'h5, 8'haa);
        bus(1, 4'h4, ctrl);
        // stall already rose at the edge that took the start
        n = (core_stall === 1'b1) ? 1 : 0;
        for (int i = 0; i < WC + 40; i++) begin
            @(posedge clk_sys);
            if (core_stall === 1'b1) n++;
            else if (n > 0 || i > 4) break;
        end
    endtask
    task automatic blanks();
        for (int i = 0; i < 16; i++) chk14(array_word[i], 14'h3fff);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #(25 * 8000);
        miscompares++;
        conclude();
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        bus(0, 4'h1, 8'h00); chk8(q, 8'h80);
        bus(0, 4'h4, 8'h00); chk8(q, 8'h80);
        bus(0, 4'h5, 8'h00); chk8(q, 8'h00);
        bus(0, 4'h9, 8'h00); chk8(q, 8'h00);
        blanks();
        // latch-only load into latch 3 of row 012
        bus(1, 4'h4, 8'h24);
        bus(1, 4'h1, 8'h01);
        put(8'h23, 14'h1234);
        start(8'h26, 1'b0);
        chk8(n[7:0], 8'h02);
        chk14(array_word[3], 14'h1234);
        chk14(array_word[4], 14'h3fff);
        chk8(prog_cnt, 8'h00);
        bus(0, 4'h4, 8'h00); chk8(q & 8'h02, 8'h00);
        // interrupted keys load nothing
        put(8'h24, 14'h0abc);
        start(8'h26, 1'b1);
        chk8(n[7:0], 8'h00);
        chk14(array_word[4], 14'h3fff);
        bus(0, 4'h4, 8'h00); chk8(q & 8'h0a, 8'h08);
        // enable clear refuses
        bus(1, 4'h4, 8'h20);
        start(8'h22, 1'b0);
        chk8(n[7:0], 8'h00);
        chk14(array_word[4], 14'h3fff);
        // last word commits the row
        bus(1, 4'h4, 8'h04);
        put(8'h2f, 14'h0555);
        start(8'h06, 1'b0);
        chk8({7'h0, n > 2}, 8'h01);
        chk8(prog_cnt, 8'h01);
        chk14(i_pfrw_flash_model.peek(15'h0123), 14'h1234);
        chk14(i_pfrw_flash_model.peek(15'h012f), 14'h0555);
        chk14(i_pfrw_flash_model.peek(15'h0120), 14'h3fff);
        chk14(i_pfrw_flash_model.peek(15'h0133), 14'h3fff);
        blanks();
        bus(0, 4'h4, 8'h00); chk8(q & 8'h02, 8'h00);
        // second program over written cells, no erase first
        put(8'h23, 14'h0ff0);
        start(8'h06, 1'b0);
        chk14(i_pfrw_flash_model.peek(15'h0123), 14'h0230);
        chk14(i_pfrw_flash_model.peek(15'h012f), 14'h0555);
        // erase with latch-only set still erases
        bus(1, 4'h4, 8'h34);
        start(8'h36, 1'b0);
        chk8(erase_cnt, 8'h01);
        chk8(prog_cnt, 8'h02);
        chk14(i_pfrw_flash_model.peek(15'h0123), 14'h3fff);
        blanks();
        // write with byte lane 0 disabled is ignored, then rewrite after the row erase
        bus(1, 4'h4, 8'h04);
        put(8'h2f, 14'h0555);
        avs_byteenable <= 4'he;
        bus(1, 4'h2, 8'h77);
        avs_byteenable <= 4'hf;
        bus(0, 4'h2, 8'h00); chk8(q, 8'h55);
        start(8'h06, 1'b0);
        chk8(prog_cnt, 8'h03);
        chk14(i_pfrw_flash_model.peek(15'h012f), 14'h0555);
        chk14(i_pfrw_flash_model.peek(15'h0123), 14'h3fff);
        blanks();
        conclude();
    end
endmodule

bind pfrw_top pfrw_top_asserts #(.WRITE_CYCLES(WRITE_CYCLES))
    i_pfrw_top_asserts (.clk_sys, .rst, .core_stall, .array_cmd, .array_word);
